// [common/timer_pkg.sv]
// Purpose: Shared constants for the dual counter/timer block.
// Assumes: Byte-wide special-function-register port, one clock.
// Notes:   Addresses and clock-select bits of timer B are local choices.
package timer_pkg;

  // ----------------------------------------------------------------
  // Register addresses on the special-function-register port
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_TIMER_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_TIMER_MODE = 8'h01;
  localparam logic [7:0] ADDR_TIMER_A_LOW = 8'h02;
  localparam logic [7:0] ADDR_TIMER_B_LOW = 8'h03;
  localparam logic [7:0] ADDR_TIMER_A_HIGH = 8'h04;
  localparam logic [7:0] ADDR_TIMER_B_HIGH = 8'h05;
  localparam logic [7:0] ADDR_CLOCK_CONTROL = 8'h06;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] TIMER_CONTROL_RESET = 8'h00;
  localparam logic [7:0] TIMER_MODE_RESET = 8'h00;
  localparam logic [7:0] CLOCK_CONTROL_RESET = 8'h00;
  localparam logic [7:0] COUNT_BYTE_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Bit positions in timer_control
  // ----------------------------------------------------------------
  localparam int TCB_B_FLAG = 7;
  localparam int TCB_B_RUN = 6;
  localparam int TCB_A_FLAG = 5;
  localparam int TCB_A_RUN = 4;

  // ----------------------------------------------------------------
  // Bit positions in timer_mode_register (per timer, B is +4)
  // ----------------------------------------------------------------
  localparam int TMB_MODE_LO = 0;
  localparam int TMB_SOURCE = 2;
  localparam int TMB_GATE = 3;
  localparam int TMB_B_OFFSET = 4;

  // ----------------------------------------------------------------
  // Bit positions in clock_control_register
  // ----------------------------------------------------------------
  localparam int CKB_PRESCALE_LO = 0;
  localparam int CKB_A_CLOCK_SELECT = 3;
  localparam int CKB_B_CLOCK_SELECT = 4;

  // ----------------------------------------------------------------
  // Mode field encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_13BIT = 2'h0;
  localparam logic [1:0] MODE_16BIT = 2'h1;
  localparam logic [1:0] MODE_RELOAD = 2'h2;
  localparam logic [1:0] MODE_SPLIT = 2'h3;

  // ----------------------------------------------------------------
  // Prescaler divide ratios, selected by prescale_select
  // ----------------------------------------------------------------
  localparam logic [7:0] PRESCALE_DIV_0 = 8'h02;
  localparam logic [7:0] PRESCALE_DIV_1 = 8'h04;
  localparam logic [7:0] PRESCALE_DIV_2 = 8'h08;
  localparam logic [7:0] PRESCALE_DIV_3 = 8'h10;

  // Pins handled by the sampler: count A, count B, gate A, gate B
  localparam int SAMPLED_PINS = 4;

endpackage

// [common/sampled_pins_if.sv]
// Purpose: Carries synchronised pin information to the timer logic.
// Assumes: Single clock domain.
// Notes:   Index 0 is timer A, index 1 is timer B.
`timescale 1ns/1ps
interface sampled_pins_if;
  logic [1:0] count_fall;
  logic [1:0] gate_level;

  modport producer (output count_fall, output gate_level);
  modport consumer (input count_fall, input gate_level);
endinterface

// [hw/pin_sampler.sv]
// Purpose: Synchronise count and gate pins, detect count-pin falls.
// Assumes: Pins are asynchronous to i_clk.
// Notes:   Output changes at the third clock edge after the pin.
`timescale 1ns/1ps
module pin_sampler
  import timer_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [1:0] i_count_pin,
  input wire logic [1:0] i_gate_pin,
  sampled_pins_if.producer pins
);

  typedef struct packed {
    logic [SAMPLED_PINS-1:0] meta;
    logic [SAMPLED_PINS-1:0] sync;
    logic [1:0] count_prev;
    logic [1:0] count_fall;
    logic [1:0] gate_level;
  } sampler_s;

  sampler_s state;
  sampler_s next_state;

  always_comb begin
    next_state = state;
    next_state.meta = {i_gate_pin, i_count_pin};
    next_state.sync = state.meta;
    // Edge detection looks only at the second stage
    next_state.count_prev = state.sync[1:0];
    for (int i = 0; i < 2; i++) begin
      next_state.count_fall[i] = state.count_prev[i] & ~state.sync[i];
    end
    next_state.gate_level = state.sync[3:2];
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign pins.count_fall = state.count_fall;
  assign pins.gate_level = state.gate_level;

endmodule

// [hw/prescale_tick.sv]
// Purpose: One-cycle tick at the prescaled clock rate.
// Assumes: Selection may change at any time; the running count is kept, not restarted.
// Notes:   Divide ratios are plain defaults from the package.
`timescale 1ns/1ps
module prescale_tick
  import timer_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [1:0] i_prescale_select,
  output logic o_tick
);

  typedef struct packed {
    logic [7:0] count;
    logic tick;
  } prescale_s;

  prescale_s state;
  prescale_s next_state;
  logic [7:0] divide;

  always_comb begin
    case (i_prescale_select)
      2'h0: divide = PRESCALE_DIV_0;
      2'h1: divide = PRESCALE_DIV_1;
      2'h2: divide = PRESCALE_DIV_2;
      default: divide = PRESCALE_DIV_3;
    endcase
  end

  always_comb begin
    next_state = state;
    // A compare of >= lets a smaller ratio take effect at once
    if (state.count >= divide - 8'h01) begin
      next_state.count = 8'h00;
      next_state.tick = 1'b1;
    end else begin
      next_state.count = state.count + 8'h01;
      next_state.tick = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign o_tick = state.tick;

endmodule

// [hw/dual_counter_timer.sv]
// Purpose: Two classic counter/timers with 13/16/8-reload modes; split mode on A only, B holds in it.
// Assumes: Inputs synchronous except the pins, which are sampled here.
// Notes:   Software writes to a count byte win over counting that cycle.
`timescale 1ns/1ps
module dual_counter_timer
  import timer_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic i_sfr_rd,
  output logic [7:0] o_sfr_rdata,
  input wire logic i_count_pin_a,
  input wire logic i_count_pin_b,
  input wire logic i_gate_input_a,
  input wire logic i_gate_input_b,
  input wire logic i_gate_a_polarity,
  input wire logic i_gate_b_polarity,
  input wire logic i_timer_a_irq_enable,
  input wire logic i_timer_b_irq_enable,
  input wire logic i_timer_a_vector_ack,
  input wire logic i_timer_b_vector_ack,
  output logic o_timer_a_irq,
  output logic o_timer_b_irq,
  output logic o_timer_b_overflow_tick
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] timer_control;
    logic [7:0] timer_mode_register;
    logic [7:0] clock_control_register;
    logic [7:0] timer_a_low_byte;
    logic [7:0] timer_a_high_byte;
    logic [7:0] timer_b_low_byte;
    logic [7:0] timer_b_high_byte;
    logic [7:0] rdata;
    logic b_tick;
  } timer_s;

  typedef struct packed {
    logic ovf;
    logic [7:0] high;
    logic [7:0] low;
  } step_s;

  timer_s state;
  timer_s next_state;

  // ----------------------------------------------------------------
  // Pin sampling and prescaler
  // ----------------------------------------------------------------
  sampled_pins_if pins ();
  logic prescaled_tick;

  pin_sampler u_pin_sampler (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_count_pin({i_count_pin_b, i_count_pin_a}),
    .i_gate_pin({i_gate_input_b, i_gate_input_a}),
    .pins(pins)
  );

  prescale_tick u_prescale_tick (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_prescale_select(
      state.clock_control_register[CKB_PRESCALE_LO +: 2]),
    .o_tick(prescaled_tick)
  );

  // ----------------------------------------------------------------
  // One counting step for modes 0, 1 and 2
  // ----------------------------------------------------------------
  function automatic step_s count_step(input logic [1:0] mode,
                                       input logic [7:0] low,
                                       input logic [7:0] high);
    step_s r;
    logic [12:0] sum13;
    logic [15:0] sum16;
    r = '{ovf: 1'b0, high: high, low: low};
    sum13 = {high, low[4:0]} + 13'h0001;
    sum16 = {high, low} + 16'h0001;
    case (mode)
      MODE_13BIT: begin
        // Upper three low-byte bits are left as they are
        r.ovf = &{high, low[4:0]};
        r.high = sum13[12:5];
        r.low = {low[7:5], sum13[4:0]};
      end
      MODE_16BIT: begin
        r.ovf = &{high, low};
        r.high = sum16[15:8];
        r.low = sum16[7:0];
      end
      MODE_RELOAD: begin
        // Reload from the high byte, which itself never changes
        r.ovf = &low;
        r.low = r.ovf ? high : low + 8'h01;
      end
      default: begin
        r.ovf = 1'b0;
      end
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Enables and time bases
  // ----------------------------------------------------------------
  logic [1:0] mode_a;
  logic [1:0] mode_b;
  logic a_split;
  logic gate_ok_a;
  logic gate_ok_b;
  logic internal_tick_a;
  logic internal_tick_b;
  logic tick_a;
  logic tick_b;
  logic run_a;
  logic run_b;
  logic run_a_high;

  always_comb begin
    mode_a = state.timer_mode_register[TMB_MODE_LO +: 2];
    mode_b = state.timer_mode_register[TMB_B_OFFSET + TMB_MODE_LO +: 2];
    a_split = (mode_a == MODE_SPLIT);
    gate_ok_a = ~state.timer_mode_register[TMB_GATE]
      | (pins.gate_level[0] == i_gate_a_polarity);
    gate_ok_b = ~state.timer_mode_register[TMB_B_OFFSET + TMB_GATE]
      | (pins.gate_level[1] == i_gate_b_polarity);
    internal_tick_a = state.clock_control_register[CKB_A_CLOCK_SELECT]
      | prescaled_tick;
    internal_tick_b = state.clock_control_register[CKB_B_CLOCK_SELECT]
      | prescaled_tick;
    tick_a = state.timer_mode_register[TMB_SOURCE] ?
      pins.count_fall[0] : internal_tick_a;
    run_a = state.timer_control[TCB_A_RUN] & gate_ok_a;
    // The split high byte has no gate and no pin clock
    run_a_high = state.timer_control[TCB_B_RUN];
    if (a_split) begin
      // Mode field alone starts and stops B here
      run_b = (mode_b != MODE_SPLIT);
      tick_b = internal_tick_b;
    end else begin
      run_b = state.timer_control[TCB_B_RUN] & gate_ok_b
        & (mode_b != MODE_SPLIT);
      tick_b = state.timer_mode_register[TMB_B_OFFSET + TMB_SOURCE] ?
        pins.count_fall[1] : internal_tick_b;
    end
  end

  // ----------------------------------------------------------------
  // Counting and overflow events
  // ----------------------------------------------------------------
  step_s step_a;
  step_s step_b;
  logic [7:0] split_low;
  logic [7:0] split_high;
  logic set_a_flag;
  logic set_b_flag;
  logic b_overflow;

  always_comb begin
    step_a = count_step(mode_a, state.timer_a_low_byte,
                        state.timer_a_high_byte);
    step_b = count_step(mode_b, state.timer_b_low_byte,
                        state.timer_b_high_byte);
    split_low = state.timer_a_low_byte;
    split_high = state.timer_a_high_byte;
    set_a_flag = 1'b0;
    set_b_flag = 1'b0;
    if (a_split) begin
      if (run_a && tick_a) begin
        split_low = state.timer_a_low_byte + 8'h01;
        set_a_flag = &state.timer_a_low_byte;
      end
      if (run_a_high && internal_tick_a) begin
        split_high = state.timer_a_high_byte + 8'h01;
        set_b_flag = &state.timer_a_high_byte;
      end
    end else if (run_a && tick_a) begin
      set_a_flag = step_a.ovf;
    end
    b_overflow = run_b & tick_b & step_b.ovf;
    if (!a_split && b_overflow) begin
      set_b_flag = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Register update
  // ----------------------------------------------------------------
  logic wr_control;

  always_comb begin
    next_state = state;
    wr_control = i_sfr_wr && (i_sfr_addr == ADDR_TIMER_CONTROL);
    next_state.b_tick = b_overflow;

    // Counting; the run bit itself never touches the count
    if (a_split) begin
      next_state.timer_a_low_byte = split_low;
      next_state.timer_a_high_byte = split_high;
    end else if (run_a && tick_a) begin
      next_state.timer_a_low_byte = step_a.low;
      next_state.timer_a_high_byte = step_a.high;
    end
    if (run_b && tick_b) begin
      next_state.timer_b_low_byte = step_b.low;
      next_state.timer_b_high_byte = step_b.high;
    end

    // Software register writes; plain R/W except the timer_control flags, which overflow and vectoring also move, and the count bytes, which counting moves
    if (i_sfr_wr) begin
      case (i_sfr_addr)
        ADDR_TIMER_CONTROL: next_state.timer_control = i_sfr_wdata;
        ADDR_TIMER_MODE: next_state.timer_mode_register = i_sfr_wdata;
        ADDR_CLOCK_CONTROL: next_state.clock_control_register = i_sfr_wdata;
        ADDR_TIMER_A_LOW: next_state.timer_a_low_byte = i_sfr_wdata;
        ADDR_TIMER_A_HIGH: next_state.timer_a_high_byte = i_sfr_wdata;
        ADDR_TIMER_B_LOW: next_state.timer_b_low_byte = i_sfr_wdata;
        ADDR_TIMER_B_HIGH: next_state.timer_b_high_byte = i_sfr_wdata;
        default: begin
        end
      endcase
    end

    // Vectoring clears a flag unless a write or new overflow says else
    if (!wr_control && i_timer_a_vector_ack) begin
      next_state.timer_control[TCB_A_FLAG] = 1'b0;
    end
    if (!wr_control && i_timer_b_vector_ack) begin
      next_state.timer_control[TCB_B_FLAG] = 1'b0;
    end
    // Set beats any clear in the same cycle so no overflow is lost
    if (set_a_flag) begin
      next_state.timer_control[TCB_A_FLAG] = 1'b1;
    end
    if (set_b_flag) begin
      next_state.timer_control[TCB_B_FLAG] = 1'b1;
    end

    // Read data is captured so the port comes from a register
    if (i_sfr_rd) begin
      case (i_sfr_addr)
        ADDR_TIMER_CONTROL: next_state.rdata = state.timer_control;
        ADDR_TIMER_MODE: next_state.rdata = state.timer_mode_register;
        ADDR_CLOCK_CONTROL: next_state.rdata = state.clock_control_register;
        ADDR_TIMER_A_LOW: next_state.rdata = state.timer_a_low_byte;
        ADDR_TIMER_A_HIGH: next_state.rdata = state.timer_a_high_byte;
        ADDR_TIMER_B_LOW: next_state.rdata = state.timer_b_low_byte;
        ADDR_TIMER_B_HIGH: next_state.rdata = state.timer_b_high_byte;
        default: next_state.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state.timer_control <= TIMER_CONTROL_RESET;
      state.timer_mode_register <= TIMER_MODE_RESET;
      state.clock_control_register <= CLOCK_CONTROL_RESET;
      state.timer_a_low_byte <= COUNT_BYTE_RESET;
      state.timer_a_high_byte <= COUNT_BYTE_RESET;
      state.timer_b_low_byte <= COUNT_BYTE_RESET;
      state.timer_b_high_byte <= COUNT_BYTE_RESET;
      state.rdata <= 8'h00;
      state.b_tick <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Request follows the flag, so it rises the cycle the flag is set
  assign o_timer_a_irq = state.timer_control[TCB_A_FLAG]
    & i_timer_a_irq_enable;
  assign o_timer_b_irq = state.timer_control[TCB_B_FLAG]
    & i_timer_b_irq_enable;
  assign o_timer_b_overflow_tick = state.b_tick;
  assign o_sfr_rdata = state.rdata;

endmodule

// [tb/timer_pin_model.sv]
// Purpose: Far-side model that drives the count and gate pins.
// Assumes: Pins change just after a rising edge of i_clk.
// Notes:   Count pins idle high; a pulse is a fall and a rise.
`timescale 1ns/1ps
module timer_pin_model (
  input wire logic i_clk,
  output logic [1:0] o_count_pin,
  output logic [1:0] o_gate_pin
);
  initial begin
    o_count_pin = 2'b11;
    o_gate_pin = 2'b00;
  end

  // Each level lasts at least two clocks so the sampler cannot miss it
  task automatic pulse(input int sel, input int n);
    repeat (n) begin
      @(posedge i_clk);
      o_count_pin[sel] <= 1'b0;
      repeat (3) @(posedge i_clk);
      o_count_pin[sel] <= 1'b1;
      repeat (2) @(posedge i_clk);
    end
  endtask

  // Called just after a rising edge; the level holds until changed
  task automatic gate(input int sel, input logic lvl);
    o_gate_pin[sel] <= lvl;
  endtask
endmodule

// [tb/dual_counter_timer_asserts.sv]
// Purpose: Port-level checks for the dual counter/timer.
// Assumes: One clock, asynchronous active-low reset.
// Notes:   Flags are seen only through reads and interrupt outputs.
`timescale 1ns/1ps
module dual_counter_timer_asserts
  import timer_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic i_sfr_rd,
  input wire logic [7:0] o_sfr_rdata,
  input wire logic i_timer_a_irq_enable,
  input wire logic i_timer_b_irq_enable,
  input wire logic i_timer_a_vector_ack,
  input wire logic o_timer_a_irq,
  input wire logic o_timer_b_irq
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  // Write to a register, then read the same one at the next edge
  sequence s_wr_rd(lo, hi);
    i_sfr_wr && i_sfr_addr >= lo && i_sfr_addr <= hi
    ##1 i_sfr_rd && !i_sfr_wr && i_sfr_addr == $past(i_sfr_addr);
  endsequence

  sequence s_irq_a_held;
    o_timer_a_irq && !i_timer_a_vector_ack
    && !(i_sfr_wr && i_sfr_addr == 8'h00) ##1 i_timer_a_irq_enable;
  endsequence

  AST_RESET_QUIET: assert property (
    $rose(i_rstn) |-> o_sfr_rdata == 8'h00 && !o_timer_a_irq
    && !o_timer_b_irq) else $error("outputs not idle after reset");
  AST_CTRL_STORE: assert property (
    s_wr_rd(8'h00, 8'h00) |=> o_sfr_rdata[3:0] == $past(i_sfr_wdata[3:0], 2))
    else $error("control low bits not stored");
  AST_BYTE_READBACK: assert property (
    s_wr_rd(8'h01, 8'h06) |=> o_sfr_rdata == $past(i_sfr_wdata, 2))
    else $error("register readback differs from write");
  AST_UNMAPPED_ZERO: assert property (
    i_sfr_rd && i_sfr_addr > 8'h06 |=> o_sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_RDATA_HOLD: assert property (
    !i_sfr_rd |=> $stable(o_sfr_rdata)) else $error("read data moved");
  AST_IRQ_A_ENABLED: assert property (
    o_timer_a_irq |-> i_timer_a_irq_enable) else $error("irq a unmasked");
  AST_IRQ_B_ENABLED: assert property (
    o_timer_b_irq |-> i_timer_b_irq_enable) else $error("irq b unmasked");
  AST_IRQ_A_STANDS: assert property (
    s_irq_a_held |-> o_timer_a_irq) else $error("irq a dropped early");
endmodule

bind dual_counter_timer dual_counter_timer_asserts i_asserts (
  .i_clk(i_clk), .i_rstn(i_rstn), .i_sfr_addr(i_sfr_addr),
  .i_sfr_wr(i_sfr_wr), .i_sfr_wdata(i_sfr_wdata), .i_sfr_rd(i_sfr_rd),
  .o_sfr_rdata(o_sfr_rdata), .i_timer_a_irq_enable(i_timer_a_irq_enable),
  .i_timer_b_irq_enable(i_timer_b_irq_enable),
  .i_timer_a_vector_ack(i_timer_a_vector_ack),
  .o_timer_a_irq(o_timer_a_irq), .o_timer_b_irq(o_timer_b_irq));

// [tb/dual_counter_timer_test.sv]
// Purpose: Self-checking bench for the dual counter/timer.
// Assumes: Reads are compared one cycle after the read edge.
// Notes:   Where a flag is read after the stop, timers are stopped by gating or a mode write so the flag survives.
`timescale 1ns/1ps
module dual_counter_timer_test
  import timer_pkg::*;
;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, rdata, v;
  logic sfr_wr = 1'b0, sfr_rd = 1'b0, rd_pend = 1'b0;
  logic pol_a = 1'b1, pol_b = 1'b1, en_a = 1'b1, en_b = 1'b1;
  logic ack_a = 1'b0, ack_b = 1'b0;
  logic irq_a, irq_b, tick;
  logic [1:0] count_pin, gate_pin;
  logic [7:0] exp_q[$];
  logic [31:0] seed;
  int num_errors = 0, checks = 0, ticks = 0, t0;

  always #12.5 clk = ~clk;

  dual_counter_timer i_dut (
    .i_clk(clk), .i_rstn(rstn), .i_sfr_addr(sfr_addr),
    .i_sfr_wr(sfr_wr), .i_sfr_wdata(sfr_wdata), .i_sfr_rd(sfr_rd),
    .o_sfr_rdata(rdata), .i_count_pin_a(count_pin[0]),
    .i_count_pin_b(count_pin[1]), .i_gate_input_a(gate_pin[0]),
    .i_gate_input_b(gate_pin[1]), .i_gate_a_polarity(pol_a),
    .i_gate_b_polarity(pol_b), .i_timer_a_irq_enable(en_a),
    .i_timer_b_irq_enable(en_b), .i_timer_a_vector_ack(ack_a),
    .i_timer_b_vector_ack(ack_b), .o_timer_a_irq(irq_a),
    .o_timer_b_irq(irq_b), .o_timer_b_overflow_tick(tick));

  timer_pin_model i_pins (
    .i_clk(clk), .o_count_pin(count_pin), .o_gate_pin(gate_pin));

  // ----------------------------------------------------------------
  // Bus tasks and comparison
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic cyc(input logic w, r, input logic [7:0] a, d);
    sfr_wr <= w;
    sfr_rd <= r;
    sfr_addr <= a;
    sfr_wdata <= d;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, d);
    cyc(1'b1, 1'b0, a, d);
  endtask

  task automatic rd(input logic [7:0] a, e);
    exp_q.push_back(e);
    cyc(1'b0, 1'b1, a, 8'h00);
  endtask

  task automatic idle(input int n);
    repeat (n) cyc(1'b0, 1'b0, 8'h00, 8'h00);
  endtask

  // Counting lasts exactly k edges: run on, then a stopping write
  task automatic run(input logic [7:0] on, a, stop, input int k);
    wr(ADDR_TIMER_CONTROL, on);
    idle(k - 1);
    wr(a, stop);
  endtask

  task automatic cmp8(input logic [7:0] got, exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge clk) begin
    if (rd_pend === 1'b1 && exp_q.size() > 0)
      cmp8(rdata, exp_q.pop_front());
    rd_pend <= sfr_rd;
    if (tick === 1'b1)
      ticks++;
  end

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    test_done();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 32'hEBA7;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    for (int a = 0; a < 8; a++)
      rd(a[7:0], 8'h00);
    rd(8'hFF, 8'h00);
    for (int a = 0; a < 7; a++) begin
      seed = lfsr_next(seed);
      v = (a == 0) ? (seed[7:0] & 8'h0F) : seed[7:0];
      wr(a[7:0], v);
      rd(a[7:0], v);
    end
    $display("test registers done");
    wr(ADDR_TIMER_MODE, 8'h33);
    wr(ADDR_CLOCK_CONTROL, 8'h18);
    wr(ADDR_TIMER_CONTROL, 8'h00);
    wr(ADDR_TIMER_A_HIGH, 8'h12);
    wr(ADDR_TIMER_A_LOW, 8'hF0);
    wr(ADDR_TIMER_MODE, 8'h01);
    run(8'h10, ADDR_TIMER_CONTROL, 8'h00, 32);
    rd(ADDR_TIMER_A_LOW, 8'h10);
    rd(ADDR_TIMER_A_HIGH, 8'h13);
    $display("test mode 1 done");
    wr(ADDR_TIMER_A_HIGH, 8'hFF);
    wr(ADDR_TIMER_A_LOW, 8'h1E);
    wr(ADDR_TIMER_MODE, 8'h00);
    run(8'h10, ADDR_TIMER_MODE, 8'h08, 3);
    rd(ADDR_TIMER_A_LOW, 8'h01);
    rd(ADDR_TIMER_A_HIGH, 8'h00);
    rd(ADDR_TIMER_CONTROL, 8'h30);
    idle(1);
    cmp8({7'h00, irq_a}, 8'h01);
    ack_a <= 1'b1;
    idle(1);
    ack_a <= 1'b0;
    rd(ADDR_TIMER_CONTROL, 8'h10);
    idle(1);
    cmp8({7'h00, irq_a}, 8'h00);
    $display("test mode 0 done");
    wr(ADDR_TIMER_CONTROL, 8'h00);
    pol_a <= 1'b0;
    wr(ADDR_TIMER_A_LOW, 8'h00);
    // Divide by two: six edges of run give exactly three ticks
    wr(ADDR_CLOCK_CONTROL, 8'h10);
    run(8'h10, ADDR_TIMER_CONTROL, 8'h00, 6);
    rd(ADDR_TIMER_A_LOW, 8'h03);
    wr(ADDR_CLOCK_CONTROL, 8'h18);
    pol_a <= 1'b1;
    $display("test gate done");
    wr(ADDR_TIMER_A_HIGH, 8'hF0);
    wr(ADDR_TIMER_A_LOW, 8'hFE);
    wr(ADDR_TIMER_MODE, 8'h02);
    run(8'h10, ADDR_TIMER_MODE, 8'h0A, 3);
    rd(ADDR_TIMER_A_LOW, 8'hF1);
    rd(ADDR_TIMER_A_HIGH, 8'hF0);
    rd(ADDR_TIMER_CONTROL, 8'h30);
    en_a <= 1'b0;
    idle(1);
    cmp8({7'h00, irq_a}, 8'h00);
    en_a <= 1'b1;
    idle(1);
    cmp8({7'h00, irq_a}, 8'h01);
    wr(ADDR_TIMER_CONTROL, 8'h00);
    wr(ADDR_TIMER_A_LOW, 8'h00);
    wr(ADDR_TIMER_MODE, 8'h04);
    wr(ADDR_TIMER_CONTROL, 8'h10);
    idle(1);
    i_pins.pulse(0, 5);
    idle(6);
    wr(ADDR_TIMER_CONTROL, 8'h00);
    rd(ADDR_TIMER_A_LOW, 8'h05);
    $display("test pin count done");
    t0 = ticks;
    wr(ADDR_TIMER_B_HIGH, 8'hFF);
    wr(ADDR_TIMER_B_LOW, 8'hFF);
    wr(ADDR_TIMER_MODE, 8'h20);
    run(8'h40, ADDR_TIMER_MODE, 8'hA0, 1);
    rd(ADDR_TIMER_B_LOW, 8'hFF);
    rd(ADDR_TIMER_CONTROL, 8'hC0);
    idle(1);
    cmp8({7'h00, irq_b}, 8'h01);
    ack_b <= 1'b1;
    idle(1);
    ack_b <= 1'b0;
    rd(ADDR_TIMER_CONTROL, 8'h40);
    cmp8(8'(ticks - t0), 8'h01);
    pol_b <= 1'b0;
    idle(1);
    pol_b <= 1'b1;
    rd(ADDR_TIMER_CONTROL, 8'hC0);
    wr(ADDR_TIMER_CONTROL, 8'h40);
    i_pins.gate(1, 1'b1);
    idle(5);
    i_pins.gate(1, 1'b0);
    idle(5);
    rd(ADDR_TIMER_CONTROL, 8'hC0);
    $display("test timer b done");
    wr(ADDR_TIMER_CONTROL, 8'h00);
    wr(ADDR_TIMER_MODE, 8'h33);
    wr(ADDR_TIMER_A_LOW, 8'h00);
    wr(ADDR_TIMER_A_HIGH, 8'hFE);
    wr(ADDR_TIMER_B_LOW, 8'hFE);
    wr(ADDR_TIMER_B_HIGH, 8'hFE);
    t0 = ticks;
    wr(ADDR_TIMER_MODE, 8'h23);
    idle(4);
    wr(ADDR_TIMER_MODE, 8'h33);
    idle(3);
    rd(ADDR_TIMER_B_LOW, 8'hFF);
    rd(ADDR_TIMER_CONTROL, 8'h00);
    cmp8(8'(ticks - t0), 8'h02);
    wr(ADDR_TIMER_B_LOW, 8'hFE);
    wr(ADDR_TIMER_MODE, 8'h23);
    wr(ADDR_TIMER_CONTROL, 8'h40);
    idle(2);
    wr(ADDR_TIMER_MODE, 8'h30);
    idle(3);
    rd(ADDR_TIMER_A_HIGH, 8'h01);
    rd(ADDR_TIMER_A_LOW, 8'h00);
    rd(ADDR_TIMER_B_LOW, 8'hFE);
    rd(ADDR_TIMER_CONTROL, 8'hC0);
    idle(3);
    $display("test split mode done");
    test_done();
  end
endmodule
